// file: hw/status_word_pkg.sv
/*
 * Constants shared by the status word block: field layout, reset values,
 * register offsets, operation codes and saturation values.
 * Assumes nothing of its surroundings.
 */
package status_word_pkg;
   localparam int SUM_WIDTH   = 32;
   localparam int TALLY_WIDTH = 6;
   localparam int SHIFT_WIDTH = 3;
   localparam int WORD_WIDTH  = 16;
   localparam int ADDR_WIDTH  = 4;

   // Field positions inside status_word_zero
   localparam int TALLY_MSB   = 15;
   localparam int TALLY_LSB   = 10;
   localparam int SHIFT_MSB   = 9;
   localparam int SHIFT_LSB   = 7;
   localparam int OVFLAG_BIT  = 6;
   localparam int SATOVF_BIT  = 1;

   // Reset values
   localparam logic [TALLY_WIDTH-1:0] TALLY_RESET = 6'h00;
   localparam logic [SHIFT_WIDTH-1:0] SHIFT_RESET = 3'h0;
   localparam logic [SUM_WIDTH-1:0]   SUM_RESET   = 32'h0000_0000;

   // Register offsets
   localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET  = 4'h0;
   localparam logic [ADDR_WIDTH-1:0] SUM_LO_OFFSET  = 4'h1;
   localparam logic [ADDR_WIDTH-1:0] SUM_HI_OFFSET  = 4'h2;
   localparam logic [ADDR_WIDTH-1:0] PROD_LO_OFFSET = 4'h3;
   localparam logic [ADDR_WIDTH-1:0] PROD_HI_OFFSET = 4'h4;
   localparam logic [ADDR_WIDTH-1:0] MODE_OFFSET    = 4'h5;
   localparam logic [ADDR_WIDTH-1:0] SCALED_LO_OFFSET = 4'h6;
   localparam logic [ADDR_WIDTH-1:0] SCALED_HI_OFFSET = 4'h7;

   // Saturation values of the main sum
   localparam logic [SUM_WIDTH-1:0] SAT_POS = 32'h7fff_ffff;
   localparam logic [SUM_WIDTH-1:0] SAT_NEG = 32'h8000_0000;

   // Shift selector codes
   localparam logic [SHIFT_WIDTH-1:0] SEL_LEFT1  = 3'h0;
   localparam logic [SHIFT_WIDTH-1:0] SEL_NONE   = 3'h1;
   localparam logic [SHIFT_WIDTH-1:0] SEL_RIGHT4 = 3'h5;

   // Execute-phase operations
   typedef enum logic [2:0] {
      OP_NONE,
      OP_SIGNED_ADD,
      OP_SIGNED_SUB,
      OP_UNSIGNED_ADD,
      OP_UNSIGNED_SUB,
      OP_COMPARE,
      OP_SATURATE,
      OP_PRODUCT_ADD
   } alu_op_e;
endpackage : status_word_pkg

// file: hw/product_scaler.sv
/*
 * Scales the multiplier result by the product shift selector.
 * Assumes a purely combinational use; no clock.
 */
`timescale 1ns/100ps
`default_nettype none
module product_scaler
   import status_word_pkg::*;
#(
   parameter int WIDTH = status_word_pkg::SUM_WIDTH
) (
   input  wire logic [WIDTH-1:0]                      product_in,
   input  wire logic [status_word_pkg::SHIFT_WIDTH-1:0] select_in,
   input  wire logic                                  alt_addressing_set_in,
   output logic      [WIDTH-1:0]                      scaled_out
);
   wire signed [WIDTH-1:0] prod_s = product_in;
   wire [2:0]              rshift = select_in - 3'h1;
   wire                    left4  = alt_addressing_set_in &&
                                    (select_in == SEL_RIGHT4);

   // Left 1 zero fill, none, arithmetic right 1..6, or left 4 zero fill for SEL_RIGHT4 with alternate addressing set
   assign scaled_out =
        (select_in == SEL_LEFT1) ? {product_in[WIDTH-2:0], 1'b0}
      : left4 ? {product_in[WIDTH-5:0], 4'h0}
      : WIDTH'(prod_s >>> rshift);
endmodule : product_scaler
`default_nettype wire

// file: hw/tally_counter.sv
/*
 * Six-bit wrapping tally with increment, decrement, clear and load.
 * Assumes synchronous active-low reset on the core clock.
 */
`timescale 1ns/100ps
`default_nettype none
module tally_counter
   import status_word_pkg::*;
#(
   parameter int WIDTH = status_word_pkg::TALLY_WIDTH
) (
   input  wire logic             clk_sys_in,
   input  wire logic             resetn_in,
   input  wire logic             inc_in,
   input  wire logic             dec_in,
   input  wire logic             clear_in,
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] load_value_in,
   output logic      [WIDTH-1:0] count_out
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   // Load beats clear beats count; wrap is natural modulo arithmetic
   assign count_d = load_in  ? load_value_in
                  : clear_in ? '0
                  : inc_in   ? count_q + 1'b1
                  : dec_in   ? count_q - 1'b1
                  : count_q;

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) count_q <= WIDTH'(TALLY_RESET);
      else            count_q <= count_d;
   end

   assign count_out = count_q;
endmodule : tally_counter
`default_nettype wire

// file: hw/status_word_zero.sv
/*
 * Status word zero of a fixed-point core: overflow tally, product shift
 * selector, overflow flag and saturate mode, with the main sum register
 * and the execute-phase update for add, subtract, compare and saturate.
 * Assumes one 250 MHz clock, synchronous active-low reset, and a register
 * port with read data one cycle after the read strobe.
 */
`timescale 1ns/100ps
`default_nettype none
module status_word_zero
   import status_word_pkg::*;
#(
   parameter int SW = status_word_pkg::SUM_WIDTH
) (
   input  wire logic                                  clk_sys_in,
   input  wire logic                                  resetn_in,
   // Register port
   input  wire logic [status_word_pkg::ADDR_WIDTH-1:0] reg_addr_in,
   input  wire logic [status_word_pkg::WORD_WIDTH-1:0] reg_wdata_in,
   input  wire logic                                  reg_write_in,
   input  wire logic                                  reg_read_in,
   output logic      [status_word_pkg::WORD_WIDTH-1:0] reg_rdata_out,
   // Execute-phase operation
   input  wire logic                                  op_valid_in,
   input  wire status_word_pkg::alu_op_e              op_code_in,
   input  wire logic [SW-1:0]                         operand_in,
   input  wire logic [SW-1:0]                         product_in,
   input  wire logic                                  product_load_in,
   // Results
   output logic      [SW-1:0]                         main_sum_out,
   output logic      [SW-1:0]                         scaled_product_out,
   output logic                                       overflow_flag_out,
   output logic      [status_word_pkg::TALLY_WIDTH-1:0] overflow_tally_out
);
   import status_word_pkg::*;

   logic [SW-1:0]          main_sum_q;
   logic [SW-1:0]          main_sum_d;
   logic [SW-1:0]          product_q;
   logic [SHIFT_WIDTH-1:0] product_shift_select_q;
   logic                   overflow_flag_q;
   logic                   overflow_flag_d;
   logic                   saturate_on_overflow_q;
   logic                   alt_addressing_set_q;
   logic [WORD_WIDTH-1:0]  rdata_q;
   logic [SW-1:0]          scaled_q;
   logic [TALLY_WIDTH-1:0] tally_q;

   wire [SW-1:0] scaled_w;

   // Product scaling toward ALU and memory
   product_scaler #(.WIDTH(SW)) u_scaler (
      .product_in            (product_q),
      .select_in             (product_shift_select_q),
      .alt_addressing_set_in (alt_addressing_set_q),
      .scaled_out            (scaled_w)
   );

   // Register port decode
   wire wr_status = reg_write_in && (reg_addr_in == STATUS_OFFSET);
   wire wr_sum_lo = reg_write_in && (reg_addr_in == SUM_LO_OFFSET);
   wire wr_sum_hi = reg_write_in && (reg_addr_in == SUM_HI_OFFSET);
   wire wr_prd_lo = reg_write_in && (reg_addr_in == PROD_LO_OFFSET);
   wire wr_prd_hi = reg_write_in && (reg_addr_in == PROD_HI_OFFSET);
   wire wr_mode   = reg_write_in && (reg_addr_in == MODE_OFFSET);

   // Operation classes
   wire do_op     = op_valid_in;
   wire is_sadd   = do_op && (op_code_in == OP_SIGNED_ADD);
   wire is_padd   = do_op && (op_code_in == OP_PRODUCT_ADD);
   wire is_ssub   = do_op && (op_code_in == OP_SIGNED_SUB);
   wire is_uadd   = do_op && (op_code_in == OP_UNSIGNED_ADD);
   wire is_usub   = do_op && (op_code_in == OP_UNSIGNED_SUB);
   wire is_sat    = do_op && (op_code_in == OP_SATURATE);
   wire is_add    = is_sadd || is_padd || is_uadd;
   wire is_sub    = is_ssub || is_usub;
   wire is_signed = is_sadd || is_padd || is_ssub;

   // Product adds use the scaled product as the addend
   wire [SW-1:0] addend = is_padd ? scaled_w : operand_in;

   // Add and subtract with carry out
   wire [SW:0] add_full = {1'b0, main_sum_q} + {1'b0, addend};
   wire [SW:0] sub_full = {1'b0, main_sum_q} - {1'b0, addend};
   wire [SW-1:0] add_res = add_full[SW-1:0];
   wire [SW-1:0] sub_res = sub_full[SW-1:0];

   // Signed overflow outside the 32-bit signed range
   wire add_pos_ovf = !main_sum_q[SW-1] && !addend[SW-1] && add_res[SW-1];
   wire add_neg_ovf = main_sum_q[SW-1] && addend[SW-1] && !add_res[SW-1];
   wire sub_pos_ovf = !main_sum_q[SW-1] && addend[SW-1] && sub_res[SW-1];
   wire sub_neg_ovf = main_sum_q[SW-1] && !addend[SW-1] && !sub_res[SW-1];
   wire pos_ovf = (is_add && add_pos_ovf) || (is_sub && sub_pos_ovf);
   wire neg_ovf = (is_add && add_neg_ovf) || (is_sub && sub_neg_ovf);
   wire any_ovf = pos_ovf || neg_ovf;

   wire carry  = is_uadd && add_full[SW];
   wire borrow = is_usub && sub_full[SW];
   wire sat_mode = saturate_on_overflow_q;

   // Tally stepping: signed counts only without saturation
   wire signed_inc = is_signed && !sat_mode && pos_ovf;
   wire signed_dec = is_signed && !sat_mode && neg_ovf;
   wire tally_inc  = signed_inc || carry;
   wire tally_dec  = (signed_dec || borrow) && !tally_inc;
   wire tally_zero = (tally_q == '0);
   wire tally_neg  = tally_q[TALLY_WIDTH-1];
   wire sat_clear  = is_sat && !tally_zero;

   // Main sum next value
   assign main_sum_d =
        (wr_sum_lo) ? {main_sum_q[SW-1:WORD_WIDTH], reg_wdata_in}
      : (wr_sum_hi) ? {reg_wdata_in, main_sum_q[WORD_WIDTH-1:0]}
      : (sat_clear) ? (tally_neg ? SAT_NEG : SAT_POS)
      : (any_ovf && sat_mode && (is_sadd || is_padd || is_ssub))
                    ? (pos_ovf ? SAT_POS : SAT_NEG)
      : (is_add)    ? add_res
      : (is_sub)    ? sub_res
      : main_sum_q;                        // compare leaves all

   // Overflow flag sets and latches; status write overrides
   assign overflow_flag_d = wr_status ? reg_wdata_in[OVFLAG_BIT]
                          : (any_ovf || (is_sat && !tally_zero))
                                     ? 1'b1 : overflow_flag_q;

   // Tally as its own counter; software write loads bits 15..10
   tally_counter #(.WIDTH(TALLY_WIDTH)) u_tally (
      .clk_sys_in    (clk_sys_in),
      .resetn_in     (resetn_in),
      .inc_in        (tally_inc),
      .dec_in        (tally_dec),
      .clear_in      (sat_clear),
      .load_in       (wr_status),
      .load_value_in (reg_wdata_in[TALLY_MSB:TALLY_LSB]),
      .count_out     (tally_q)
   );

   // Execute-phase update of sum and flag
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         main_sum_q      <= SUM_RESET;
         overflow_flag_q <= 1'b0;
      end else begin
         main_sum_q      <= main_sum_d;
         overflow_flag_q <= overflow_flag_d;
      end
   end

   // Product register, loaded by multiplier or software
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in)           product_q <= SUM_RESET;
      else if (product_load_in) product_q <= product_in;
      else if (wr_prd_lo)
         product_q <= {product_q[SW-1:WORD_WIDTH], reg_wdata_in};
      else if (wr_prd_hi)
         product_q <= {reg_wdata_in, product_q[WORD_WIDTH-1:0]};
   end

   // Control fields of the status word and mode register
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         product_shift_select_q <= SHIFT_RESET;
         saturate_on_overflow_q <= 1'b0;
         alt_addressing_set_q   <= 1'b0;
      end else begin
         if (wr_status) begin
            product_shift_select_q <= reg_wdata_in[SHIFT_MSB:SHIFT_LSB];
            saturate_on_overflow_q <= reg_wdata_in[SATOVF_BIT];
         end
         if (wr_mode) alt_addressing_set_q <= reg_wdata_in[0];
      end
   end

   // Read mux
   wire [WORD_WIDTH-1:0] status_word = {tally_q, product_shift_select_q,
      overflow_flag_q, 4'h0, saturate_on_overflow_q, 1'b0};
   wire [WORD_WIDTH-1:0] rd_mux =
        (reg_addr_in == STATUS_OFFSET)    ? status_word
      : (reg_addr_in == SUM_LO_OFFSET)    ? main_sum_q[WORD_WIDTH-1:0]
      : (reg_addr_in == SUM_HI_OFFSET)    ? main_sum_q[SW-1:WORD_WIDTH]
      : (reg_addr_in == PROD_LO_OFFSET)   ? product_q[WORD_WIDTH-1:0]
      : (reg_addr_in == PROD_HI_OFFSET)   ? product_q[SW-1:WORD_WIDTH]
      : (reg_addr_in == MODE_OFFSET)      ? {15'h0000, alt_addressing_set_q}
      : (reg_addr_in == SCALED_LO_OFFSET) ? scaled_w[WORD_WIDTH-1:0]
      : (reg_addr_in == SCALED_HI_OFFSET) ? scaled_w[SW-1:WORD_WIDTH]
      : 16'h0000;

   // Read data one cycle after strobe; registered scaled product
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         rdata_q  <= 16'h0000;
         scaled_q <= SUM_RESET;
      end else begin
         rdata_q  <= reg_read_in ? rd_mux : 16'h0000;
         scaled_q <= scaled_w;
      end
   end

   assign reg_rdata_out      = rdata_q;
   assign main_sum_out       = main_sum_q;
   assign scaled_product_out = scaled_q;
   assign overflow_flag_out  = overflow_flag_q;
   assign overflow_tally_out = tally_q;

   // Assertions
   tally_wrap_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (tally_inc && !wr_status && !sat_clear && tally_q == 6'h1f)
      |=> tally_q == 6'h20) else $error("tally did not wrap up");
   tally_dec_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (tally_dec && !wr_status && !sat_clear)
      |=> tally_q == $past(tally_q) - 6'h01) else $error("no decrement");
   sat_hold_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (sat_mode && any_ovf && !is_uadd && !is_usub && !wr_status)
      |=> $stable(tally_q)) else $error("tally moved in saturation");
   sat_value_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (sat_mode && pos_ovf && is_sadd && !wr_sum_lo && !wr_sum_hi)
      |=> main_sum_q == SAT_POS) else $error("no positive saturation");
   signed_inc_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (!sat_mode && is_sadd && pos_ovf && !wr_status)
      |=> tally_q == $past(tally_q) + 6'h01 && overflow_flag_q)
      else $error("signed overflow not counted");
   satop_zero_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (is_sat && tally_zero && !reg_write_in) |=> $stable(main_sum_q))
      else $error("saturate op changed sum");
   satop_clear_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (is_sat && !tally_zero && !wr_status) |=> tally_q == 6'h00)
      else $error("saturate op left tally");
   compare_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      (do_op && op_code_in == OP_COMPARE && !reg_write_in)
      |=> $stable(tally_q) && $stable(main_sum_q)) else $error("compare moved");
   flag_latch_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      overflow_flag_q && !wr_status |=> overflow_flag_q)
      else $error("flag dropped");
   reset_zero_a: assert property (@(posedge clk_sys_in)
      !resetn_in |=> tally_q == 6'h00 && product_shift_select_q == 3'h0)
      else $error("reset value wrong");
   scale_left_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      product_shift_select_q == SEL_LEFT1 |=> scaled_q == {$past(product_q[SW-2:0]), 1'b0})
      else $error("left shift wrong");
   rdata_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
      !reg_read_in |=> reg_rdata_out == 16'h0000) else $error("stray read data");

   carry_inc_a: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in) carry && !wr_status
      |=> tally_q == $past(tally_q) + 6'h01) else $error("carry lost");
   signed_dec_a: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in)
      !sat_mode && is_signed && neg_ovf && !wr_status
      |=> tally_q == $past(tally_q) - 6'h01) else $error("no signed dec");
   wrap_down_a: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in)
      tally_dec && !wr_status && !sat_clear && tally_q == 6'h20
      |=> tally_q == 6'h1f) else $error("tally did not wrap down");
   sat_neg_a: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in)
      sat_mode && neg_ovf && is_signed && !wr_sum_lo && !wr_sum_hi
      |=> main_sum_q == SAT_NEG) else $error("no negative saturation");
   flag_set_a: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in) any_ovf && !wr_status
      |=> overflow_flag_q) else $error("flag not set");
   scale_none_a: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in) product_shift_select_q == SEL_NONE
      |=> scaled_q == $past(product_q)) else $error("no-shift wrong");
   scale_left4_a: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in)
      alt_addressing_set_q && product_shift_select_q == SEL_RIGHT4
      |=> scaled_q == {$past(product_q[SW-5:0]), 4'h0})
      else $error("left four wrong");
   sel_write_a: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in) wr_status |=> product_shift_select_q ==
      $past(reg_wdata_in[SHIFT_MSB:SHIFT_LSB]))
      else $error("selector write lost");

   wrap_c:  cover property (@(posedge clk_sys_in) tally_q == 6'h1f ##1 tally_q == 6'h20);
   negadd_c: cover property (@(posedge clk_sys_in) is_sadd && neg_ovf);
   satop_c: cover property (@(posedge clk_sys_in) sat_clear && tally_neg);
   carry_c: cover property (@(posedge clk_sys_in) carry);
   left4_c: cover property (@(posedge clk_sys_in)
      alt_addressing_set_q && product_shift_select_q == SEL_RIGHT4);
endmodule : status_word_zero
`default_nettype wire

// file: tb/tb_top.sv
/*
 * Self-checking bench for the status word block: register access, shift
 * selector table, tally counting, wrap, saturation and random op runs.
 * Assumes the design package is compiled first; no partner model.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import status_word_pkg::*;
   logic            clk_sys_in, resetn_in, reg_write_in, reg_read_in;
   logic [3:0]      reg_addr_in;
   logic [15:0]     reg_wdata_in, reg_rdata_out, rd, rh;
   logic            op_valid_in, product_load_in, overflow_flag_out;
   alu_op_e         op_code_in;
   logic [31:0]     operand_in, product_in, main_sum_out, scaled_product_out;
   logic [5:0]      overflow_tally_out, m_tally;
   logic [31:0]     m_sum, p;
   logic [2:0]      m_sel;
   logic            m_flag, m_sat;
   logic [15:0]     lfsr_q;
   int              fail_count, n_checks;
   // Corner tallies for the saturate op
   logic [5:0]      sat_tallies [5] = '{6'h00, 6'h05, 6'h3e, 6'h1f, 6'h20};

   status_word_zero dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
      .reg_rdata_out(reg_rdata_out), .op_valid_in(op_valid_in),
      .op_code_in(op_code_in), .operand_in(operand_in),
      .product_in(product_in), .product_load_in(product_load_in),
      .main_sum_out(main_sum_out), .scaled_product_out(scaled_product_out),
      .overflow_flag_out(overflow_flag_out),
      .overflow_tally_out(overflow_tally_out));

   // Free-running 250 MHz core clock
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   // Pseudo-random words from a 16-bit shift register
   function automatic logic [31:0] rnd32();
      logic [31:0] v;
      v = '0;
      for (int i = 0; i < 32; i++) begin
         lfsr_q = {lfsr_q[14:0], lfsr_q[15]^lfsr_q[13]^lfsr_q[12]^lfsr_q[10]};
         v = {v[30:0], lfsr_q[0]};
      end
      return v;
   endfunction : rnd32

   // Expected product after the shift selector
   function automatic logic [31:0] scale(logic [31:0] v, logic [2:0] s,
                                         logic a);
      if (s == SEL_LEFT1) return {v[30:0], 1'b0};
      if (s == SEL_NONE) return v;
      if (s == SEL_RIGHT4 && a) return {v[27:0], 4'h0};
      return $signed(v) >>> (s - 3'h1);
   endfunction : scale

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict

   // One-cycle register write and read strobes
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      reg_write_in <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_write_in <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys_in);
      reg_read_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_read_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask : reg_rd

   task automatic prod_ld(input logic [31:0] v);
      @(posedge clk_sys_in);
      product_load_in <= 1'b1;
      product_in      <= v;
      @(posedge clk_sys_in);
      product_load_in <= 1'b0;
   endtask : prod_ld

   // Load status and sum, mirror them in the model
   task automatic set_state(input logic [31:0] s, input logic [5:0] t,
                            input logic [2:0] sel, input logic sat);
      reg_wr(STATUS_OFFSET, {t, sel, 1'b0, 4'h0, sat, 1'b0});
      reg_wr(SUM_LO_OFFSET, s[15:0]);
      reg_wr(SUM_HI_OFFSET, s[31:16]);
      m_sum = s;
      m_tally = t;
      m_sel = sel;
      m_flag = 1'b0;
      m_sat = sat;
   endtask : set_state

   // One execute op, model update, then compare the results
   task automatic do_op(input alu_op_e op, input logic [31:0] o,
                        input bit fchk);
      logic [32:0] w;
      logic        ovf;
      logic        pos;
      @(posedge clk_sys_in);
      op_valid_in <= 1'b1;
      op_code_in  <= op;
      operand_in  <= o;
      @(posedge clk_sys_in);
      op_valid_in <= 1'b0;
      ovf = 1'b0;
      pos = ~m_sum[31];
      w = {1'b0, m_sum};
      case (op)
         OP_SIGNED_ADD, OP_PRODUCT_ADD: begin
            w = {1'b0, m_sum} + {1'b0, o};
            ovf = (m_sum[31] == o[31]) && (w[31] != m_sum[31]);
         end
         OP_SIGNED_SUB: begin
            w = {1'b0, m_sum} - {1'b0, o};
            ovf = (m_sum[31] != o[31]) && (w[31] != m_sum[31]);
         end
         OP_UNSIGNED_ADD: begin
            w = {1'b0, m_sum} + {1'b0, o};
            m_tally = m_tally + {5'h00, w[32]};
         end
         OP_UNSIGNED_SUB: begin
            w = {1'b0, m_sum} - {1'b0, o};
            m_tally = m_tally - {5'h00, w[32]};
         end
         OP_SATURATE: begin
            if (m_tally != 6'h00) begin
               w[31:0] = m_tally[5] ? SAT_NEG : SAT_POS;
               m_tally = 6'h00;
               m_flag = 1'b1;
            end
         end
         default: w = {1'b0, m_sum};
      endcase
      if (ovf) begin
         m_flag = 1'b1;
         if (m_sat) w[31:0] = pos ? SAT_POS : SAT_NEG;
         else m_tally = pos ? m_tally + 6'h01 : m_tally - 6'h01;
      end
      m_sum = w[31:0];
      #1;
      chk("sum", m_sum, main_sum_out);
      chk("tally", {26'h0, m_tally}, {26'h0, overflow_tally_out});
      if (fchk) chk("flag", {31'h0, m_flag}, {31'h0, overflow_flag_out});
   endtask : do_op

   // Watchdog against a hung run
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      fail_count++;
      $display("BAD run_length expected finish seen hang");
      print_verdict();
   end

   initial begin
      lfsr_q = 16'hc214;
      resetn_in = 1'b0;
      reg_write_in = 1'b0;
      reg_read_in = 1'b0;
      reg_addr_in = 4'h0;
      reg_wdata_in = 16'h0000;
      op_valid_in = 1'b0;
      op_code_in = OP_NONE;
      operand_in = 32'h0;
      product_in = 32'h0;
      product_load_in = 1'b0;
      fail_count = 0;
      n_checks = 0;
      repeat (10) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      // Reset values and an unmapped index
      reg_rd(STATUS_OFFSET, rd);
      chk("status_reset", 32'h0, {16'h0, rd});
      reg_rd(4'h8, rd);
      chk("unmapped", 32'h0, {16'h0, rd});
      chk("sum_reset", 32'h0, main_sum_out);
      $display("test reset done");
      // Status fields read back what was written
      for (int i = 0; i < 8; i++) begin
         p = rnd32();
         reg_wr(STATUS_OFFSET, p[15:0]);
         reg_rd(STATUS_OFFSET, rd);
         chk("status_rw", {16'h0, p[15:0] & 16'hffc2}, {16'h0, rd});
      end
      $display("test status access done");
      // Every selector code with and without alternate addressing
      for (int i = 0; i < 16; i++) begin
         reg_wr(MODE_OFFSET, {15'h0, i[3]});
         reg_wr(STATUS_OFFSET, {6'h00, i[2:0], 7'h00});
         p = rnd32();
         p[31] = i[0];
         prod_ld(p);
         @(posedge clk_sys_in);
         #1 chk("scaled", scale(p, i[2:0], i[3]), scaled_product_out);
         reg_rd(SCALED_LO_OFFSET, rd);
         reg_rd(SCALED_HI_OFFSET, rh);
         chk("scaled_reg", scale(p, i[2:0], i[3]), {rh, rd});
      end
      $display("test shift select done");
      // Signed overflow both ways through the wrap points, then compare
      set_state(SAT_POS, 6'h1f, SEL_NONE, 1'b0);
      do_op(OP_SIGNED_ADD, 32'h1, 1);
      do_op(OP_SIGNED_SUB, 32'h1, 1);
      do_op(OP_COMPARE, SAT_NEG, 1);
      // Saturation mode on: tally held, sum clamped
      set_state(32'h7fff_fffa, 6'h03, SEL_NONE, 1'b1);
      do_op(OP_SIGNED_ADD, 32'h10, 1);
      set_state(32'h8000_0002, 6'h03, SEL_NONE, 1'b1);
      do_op(OP_SIGNED_SUB, 32'h10, 1);
      // Unsigned carry and borrow across the wrap points
      set_state(32'hffff_ffff, 6'h1f, SEL_NONE, 1'b0);
      do_op(OP_UNSIGNED_ADD, 32'h1, 0);
      do_op(OP_UNSIGNED_SUB, 32'h1, 0);
      $display("test overflow counting done");
      // Saturate op for zero, positive and negative tallies
      for (int k = 0; k < 5; k++) begin
         set_state(rnd32(), sat_tallies[k], SEL_NONE, 1'b0);
         do_op(OP_SATURATE, 32'h0, 1);
      end
      // Scaled product added to the sum overflows upward
      set_state(32'h7fff_fff0, 6'h00, 3'h2, 1'b0);
      prod_ld(32'h0000_0100);
      do_op(OP_PRODUCT_ADD, scale(32'h100, 3'h2, 1'b1), 1);
      $display("test saturate done");
      // Random op stream against the model
      p = rnd32();
      set_state(rnd32(), p[5:0], SEL_NONE, p[6]);
      for (int i = 0; i < 300; i++) begin
         p = rnd32();
         do_op(alu_op_e'(3'(32'd1 + p % 32'd5)), rnd32(), 0);
      end
      $display("test random ops done");
      // Reset in mid-run clears everything again
      @(posedge clk_sys_in);
      resetn_in <= 1'b0;
      @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      reg_rd(STATUS_OFFSET, rd);
      chk("status_rerun", 32'h0, {16'h0, rd});
      chk("sum_rerun", 32'h0, main_sum_out);
      $display("test second reset done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
